// [rtl/rtcas_top.sv]
// Overview of operation
// - Writing 1 to reset bit resets prescaler; reads 1 until done, then self-clears.
// - Run bit 0 stops time count keeping value; 1 resumes from it.
// - Second alarm holds BCD tens in 14-12, units in 11-8; rest zero.
// - Alarm half-day bit 14 selects P.M.; used only in 12-hour mode.
// - Alarm hour BCD tens 13-12, units 11-8; 1-12 or 0-23.
// - Alarm minute BCD tens 6-4, units 3-0; bit 7 reads zero.
// - Stopwatch register shows tenths in 15-12, hundredths in 11-8, read-only.
// - Stopwatch clear bit 4 zeroes count; running continues; always reads 0.
// - Stopwatch run bit 0 starts and stops; stopped count kept.
// - Stopwatch halts at next stopwatch clock edge; may advance by one.
// - Second register reads and writes BCD tens 14-12, units 11-8.
// - Second register bits 7-0 show prescaler stages, 1 Hz down to 128 Hz.
// - Prescaler taps forced to zero when reset bit is set.
// - Half-day bit 14 holds P.M. in 12-hour mode; reads 0 in 24-hour.
// - Half-day bit left at 1 in 24-hour mode clears at next hour step.
// - Hour count BCD tens 13-12, units 11-8; 1-12 or 0-23.
// - Busy flag rises on each second step and holds for 1/256 second.
// - Hour mode bit 4 set to 1 selects 24-hour range; stored hour is not rewritten.
// - Alarm flag sets 1/256 second after time equals alarm setting.
`timescale 1ns/1ps
module rtcas_top #(
    parameter int P_TICK_CYCLES = rtcas_pkg::TICK_CYCLES,
    parameter int P_SW_CYCLES = rtcas_pkg::SW_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr
);

    // Zero-wait register file. Time, taps and alarm step on a divided tick
    // of the bus clock, the stopwatch on a tick of its own. There is no
    // interrupt line: a match shows only as a status flag.

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    // All state but the stopwatch divider, run sample and count lives in this one struct. The alarm bytes keep a zero top
    // bit, so they compare directly with the time bytes. The clear strobe
    // is the only field that is dropped on every cycle.
    typedef struct packed {
        logic run;
        logic rst_busy;
        logic [1:0] rst_cnt;
        logic h24;
        logic busy;
        logic alarm_f;
        logic [rtcas_pkg::DIV_W-1:0] div;
        logic [7:0] pre;
        logic [7:0] sec;
        logic [7:0] min;
        logic [7:0] hour;
        logic ap;
        logic [7:0] a_sec;
        logic [7:0] a_min;
        logic [7:0] a_hour;
        logic a_ap;
        logic sw_run;
        logic sw_clr;
        logic [31:0] prdata;
    } rtcas_state_type;

    rtcas_state_type s_q;
    rtcas_state_type s_d;
    rtcas_sw_if sw_bus ();
    logic tick;
    logic match;
    logic wr;
    logic [15:0] wd;

    // ------------------------------------------------------------
    // Stopwatch
    // ------------------------------------------------------------
    // The stopwatch steps on its own tick, so a stop takes hold only there
    // and software may see one more step after it has stopped the count.
    rtcas_stopwatch #(
        .P_SW_CYCLES(P_SW_CYCLES)
    ) u_sw (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .sw(sw_bus.cnt)
    );

    // The clear strobe lasts one cycle; the counter sees it one edge late.
    assign sw_bus.run = s_q.sw_run;
    assign sw_bus.clear = s_q.sw_clr;

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------

    // Tells whether an offset names a register.
    // It feeds the error response; writes to other offsets are dropped.
    function automatic logic is_mapped(input logic [7:0] a);
        return (a == rtcas_pkg::OFS_CTRL) || (a == rtcas_pkg::OFS_SEC_ALARM) ||
               (a == rtcas_pkg::OFS_HM_ALARM) || (a == rtcas_pkg::OFS_SW_CTRL) ||
               (a == rtcas_pkg::OFS_SEC) || (a == rtcas_pkg::OFS_HM) || (a == rtcas_pkg::OFS_STATUS);
    endfunction

    // Builds the read word for an offset.
    // Reserved bits and the write-only clear bit read as zero, and so do
    // offsets that name no register.
    function automatic logic [31:0] read_word(input logic [7:0] a, input rtcas_state_type s, input logic [7:0] swd);
        logic [31:0] r;
        r = '0;
        unique case (a)
            rtcas_pkg::OFS_CTRL: begin
                r[rtcas_pkg::CTRL_RUN] = s.run;
                r[rtcas_pkg::CTRL_RST] = s.rst_busy;
                r[rtcas_pkg::CTRL_H24] = s.h24;
                r[rtcas_pkg::CTRL_BUSY] = s.busy;
            end
            rtcas_pkg::OFS_SEC_ALARM: begin
                r[14:8] = s.a_sec[6:0];
            end
            rtcas_pkg::OFS_HM_ALARM: begin
                r[rtcas_pkg::HALF_DAY] = s.a_ap;
                r[13:8] = s.a_hour[5:0];
                r[6:0] = s.a_min[6:0];
            end
            rtcas_pkg::OFS_SW_CTRL: begin
                r[15:8] = swd;
                r[rtcas_pkg::SW_RUN] = s.sw_run;
            end
            rtcas_pkg::OFS_SEC: begin
                r[14:8] = s.sec[6:0];
                r[7:0] = s.pre;
            end
            rtcas_pkg::OFS_HM: begin
                r[rtcas_pkg::HALF_DAY] = s.ap & ~s.h24;
                r[13:8] = s.hour[5:0];
                r[6:0] = s.min[6:0];
            end
            rtcas_pkg::OFS_STATUS: begin
                r[rtcas_pkg::STAT_ALARM] = s.alarm_f;
            end
            default: begin
                r = '0;
            end
        endcase
        return r;
    endfunction

    // ------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------

    // No wait states: read data were taken at the setup edge and have
    // settled when the master samples them; writes land at the access edge.

    // Every access completes in its first access cycle.
    assign o_pready = i_psel & i_penable;
    assign o_pslverr = i_psel & i_penable & ~is_mapped(i_paddr);
    assign o_prdata = s_q.prdata;
    assign wr = i_psel & i_penable & i_pwrite;
    assign wd = i_pwdata[15:0];

    // The divider halts with the clock, so a stop keeps the partial tick
    // as well as the tap pattern.
    // The 256 Hz prescaler clock edge.
    assign tick = (s_q.div == rtcas_pkg::DIV_W'(P_TICK_CYCLES - 1));

    // It is judged at the end of busy, so the flag rises one tick later.
    // Time equals the alarm; half-day only counts in 12-hour mode.
    assign match = (s_q.sec == s_q.a_sec) && (s_q.min == s_q.a_min) && (s_q.hour == s_q.a_hour) &&
                   (s_q.h24 || (s_q.ap == s_q.a_ap));

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------

    // Counting comes first, then the prescaler reset, then software writes,
    // so a write wins over a step in the same cycle, except an alarm flag clear, which loses to a match.
    always_comb begin
        s_d = s_q;
        s_d.sw_clr = 1'b0;

        // A read therefore shows the state as it stood before that edge.
        // Read data is captured in the setup cycle.
        if (i_psel && !i_penable && !i_pwrite) begin
            s_d.prdata = read_word(i_paddr, s_q, sw_bus.digits);
        end

        // Prescaler runs only while the clock runs; the count is kept otherwise.
        if (s_q.run) begin
            s_d.div = tick ? '0 : s_q.div + rtcas_pkg::DIV_W'(1);
        end
        if (s_q.run && tick) begin
            s_d.pre = s_q.pre + 8'h01;
            // Busy lasts one prescaler period and the alarm is judged at its end.
            if (s_q.busy) begin
                s_d.busy = 1'b0;
                if (match) begin
                    s_d.alarm_f = 1'b1;
                end
            end
            // The wrap of the taps is the one-second step.
            if (s_q.pre == 8'hFF) begin
                s_d.busy = 1'b1;
                s_d.sec = rtcas_pkg::bcd_inc(s_q.sec, rtcas_pkg::TOP_59, rtcas_pkg::ZERO_BCD);
                if (s_q.sec == rtcas_pkg::TOP_59) begin
                    s_d.min = rtcas_pkg::bcd_inc(s_q.min, rtcas_pkg::TOP_59, rtcas_pkg::ZERO_BCD);
                    if (s_q.min == rtcas_pkg::TOP_59) begin
                        if (s_q.h24) begin
                            s_d.hour = rtcas_pkg::bcd_inc(s_q.hour, rtcas_pkg::TOP_23, rtcas_pkg::ZERO_BCD);
                            s_d.ap = 1'b0;
                        end else begin
                            // The half-day flips as 11 steps on to 12.
                            s_d.hour = rtcas_pkg::bcd_inc(s_q.hour, rtcas_pkg::TOP_12, rtcas_pkg::ONE_BCD);
                            if (s_q.hour == rtcas_pkg::HOUR_11) begin
                                s_d.ap = ~s_q.ap;
                            end
                        end
                    end
                end
            end
        end

        // A short fixed span lets software see the control bit read back
        // as 1 before it clears itself.
        // Prescaler reset holds the divider and taps at zero until it ends.
        if (s_q.rst_busy) begin
            s_d.div = '0;
            s_d.pre = 8'h00;
            s_d.rst_cnt = s_q.rst_cnt - 2'h1;
            if (s_q.rst_cnt == 2'h1) begin
                s_d.rst_busy = 1'b0;
            end
        end

        // Time writes are not blocked while busy; software must wait for
        // idle before it touches the time fields.
        // Register writes.
        if (wr) begin
            unique case (i_paddr)
                rtcas_pkg::OFS_CTRL: begin
                    s_d.run = wd[rtcas_pkg::CTRL_RUN];
                    s_d.h24 = wd[rtcas_pkg::CTRL_H24];
                    if (wd[rtcas_pkg::CTRL_RST]) begin
                        s_d.rst_busy = 1'b1;
                        s_d.rst_cnt = rtcas_pkg::RST_CYCLES;
                        s_d.div = '0;
                        s_d.pre = 8'h00;
                    end
                end
                rtcas_pkg::OFS_SEC_ALARM: begin
                    s_d.a_sec = {1'b0, wd[14:8]};
                end
                rtcas_pkg::OFS_HM_ALARM: begin
                    s_d.a_ap = wd[rtcas_pkg::HALF_DAY];
                    s_d.a_hour = {2'h0, wd[13:8]};
                    s_d.a_min = {1'b0, wd[6:0]};
                end
                rtcas_pkg::OFS_SW_CTRL: begin
                    s_d.sw_run = wd[rtcas_pkg::SW_RUN];
                    s_d.sw_clr = wd[rtcas_pkg::SW_CLR];
                end
                rtcas_pkg::OFS_SEC: begin
                    s_d.sec = {1'b0, wd[14:8]};
                end
                rtcas_pkg::OFS_HM: begin
                    s_d.hour = {2'h0, wd[13:8]};
                    s_d.min = {1'b0, wd[6:0]};
                    if (!s_q.h24) begin
                        s_d.ap = wd[rtcas_pkg::HALF_DAY];
                    end
                end
                rtcas_pkg::OFS_STATUS: begin
                    // Write 1 clears, but a match in the same cycle wins.
                    if (wd[rtcas_pkg::STAT_ALARM] && !(s_q.run && tick && s_q.busy && match)) begin
                        s_d.alarm_f = 1'b0;
                    end
                end
                default: begin
                    s_d.run = s_q.run;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------

    // Only constants load on reset. Every field starts at zero except the
    // hour, which starts at 12 A.M.
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            s_q <= '0;
            s_q.hour <= rtcas_pkg::HOUR_RESET;
        end else begin
            s_q <= s_d;
        end
    end

endmodule

// [rtl/rtcas_pkg.sv]
package rtcas_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 20_000_000;
    localparam int TICK_HZ = 256;
    localparam int SW_HZ = 100;
    localparam int TICK_CYCLES = CLK_HZ / TICK_HZ;
    localparam int SW_CYCLES = CLK_HZ / SW_HZ;
    localparam int DIV_W = 18;
    localparam logic [1:0] RST_CYCLES = 2'h2;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_SEC_ALARM = 8'h04;
    localparam logic [7:0] OFS_HM_ALARM = 8'h08;
    localparam logic [7:0] OFS_SW_CTRL = 8'h0C;
    localparam logic [7:0] OFS_SEC = 8'h10;
    localparam logic [7:0] OFS_HM = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTRL_RUN = 0;
    localparam int CTRL_RST = 1;
    localparam int CTRL_H24 = 4;
    localparam int CTRL_BUSY = 6;
    localparam int STAT_ALARM = 0;
    localparam int SW_RUN = 0;
    localparam int SW_CLR = 4;
    localparam int HALF_DAY = 14;
    localparam int HI_TENS_LSB = 12;
    localparam int HI_UNITS_LSB = 8;
    localparam int LO_TENS_LSB = 4;

    // ------------------------------------------------------------
    // Reset values and BCD limits
    // ------------------------------------------------------------
    localparam logic [7:0] HOUR_RESET = 8'h12;
    localparam logic [7:0] ZERO_BCD = 8'h00;
    localparam logic [7:0] ONE_BCD = 8'h01;
    localparam logic [7:0] TOP_59 = 8'h59;
    localparam logic [7:0] TOP_99 = 8'h99;
    localparam logic [7:0] TOP_23 = 8'h23;
    localparam logic [7:0] TOP_12 = 8'h12;
    localparam logic [7:0] HOUR_11 = 8'h11;
    localparam logic [3:0] NINE = 4'h9;

    // Two-digit BCD step that wraps from top back to bottom.
    function automatic logic [7:0] bcd_inc(input logic [7:0] v, input logic [7:0] top, input logic [7:0] bottom);
        logic [7:0] r;
        r = v;
        if (v == top) begin
            r = bottom;
        end else if (v[3:0] == NINE) begin
            r = {v[7:4] + 4'h1, 4'h0};
        end else begin
            r = {v[7:4], v[3:0] + 4'h1};
        end
        return r;
    endfunction

endpackage

// [rtl/rtcas_sw_if.sv]
`timescale 1ns/1ps
interface rtcas_sw_if;
    logic run;
    logic clear;
    logic [7:0] digits;

    modport ctrl (output run, output clear, input digits);
    modport cnt (input run, input clear, output digits);
endinterface

// [rtl/rtcas_stopwatch.sv]
`timescale 1ns/1ps
module rtcas_stopwatch #(
    parameter int P_SW_CYCLES = rtcas_pkg::SW_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    rtcas_sw_if.cnt sw
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [rtcas_pkg::DIV_W-1:0] div;
        logic run_eff;
        logic [7:0] count;
    } rtcas_sw_state_type;

    rtcas_sw_state_type s_q;
    rtcas_sw_state_type s_d;
    logic tick;

    // The 100 Hz stopwatch clock edge is the wrap of the divider.
    assign tick = (s_q.div == rtcas_pkg::DIV_W'(P_SW_CYCLES - 1));

    // Count on the stopwatch clock; the run level is only sampled there.
    always_comb begin
        s_d = s_q;
        s_d.div = tick ? '0 : s_q.div + rtcas_pkg::DIV_W'(1);
        if (tick) begin
            s_d.run_eff = sw.run;
            if (s_q.run_eff) begin
                s_d.count = rtcas_pkg::bcd_inc(s_q.count, rtcas_pkg::TOP_99, rtcas_pkg::ZERO_BCD);
            end
        end
        if (sw.clear) begin
            s_d.count = rtcas_pkg::ZERO_BCD;
        end
    end

    // Registers.
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign sw.digits = s_q.count;

endmodule

// [tb/rtcas_top_checker.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------
// Port-level checker for the clock block
// ------------------------------------------------------------
module rtcas_top_checker (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr
);
    logic acc;
    logic rd;
    logic map;
    logic [6:0] alm_q;

    // Access phase, read access and the mapped word offsets.
    assign acc = i_psel && i_penable;
    assign rd = acc && !i_pwrite;
    assign map = i_paddr[1:0] == 2'h0 && i_paddr <= rtcas_pkg::OFS_STATUS;

    // Shadow of the last second alarm value written.
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            alm_q <= 7'h00;
        end else if (acc && i_pwrite && i_paddr == rtcas_pkg::OFS_SEC_ALARM) begin
            alm_q <= i_pwdata[14:8];
        end
    end

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_nrst);

    ready_access_a: assert property (o_pready == acc)
        else $error("pready differs from the access phase");
    unmapped_err_a: assert property (acc && !map |-> o_pslverr)
        else $error("unmapped access without slave error");
    mapped_ok_a: assert property (acc && map |-> !o_pslverr)
        else $error("slave error on a mapped register");
    unmapped_zero_a: assert property (rd && !map |-> o_prdata == 32'h0000_0000)
        else $error("unmapped read returned data");
    sec_alarm_a: assert property (rd && i_paddr == rtcas_pkg::OFS_SEC_ALARM |->
        o_prdata == {17'h00000, alm_q, 8'h00}) else $error("second alarm read differs from last write");
    hm_alarm_rsv_a: assert property (rd && i_paddr == rtcas_pkg::OFS_HM_ALARM |->
        o_prdata[31:15] == 17'h00000 && !o_prdata[7]) else $error("hour/minute alarm reserved bit set");
    sw_rsv_a: assert property (rd && i_paddr == rtcas_pkg::OFS_SW_CTRL |->
        o_prdata[31:16] == 16'h0000 && o_prdata[7:1] == 7'h00) else $error("stopwatch clear or reserved bit read 1");
    sw_bcd_a: assert property (rd && i_paddr == rtcas_pkg::OFS_SW_CTRL |->
        o_prdata[15:12] <= 4'h9 && o_prdata[11:8] <= 4'h9) else $error("stopwatch digit beyond nine");
    sec_bcd_a: assert property (rd && i_paddr == rtcas_pkg::OFS_SEC |->
        !o_prdata[15] && o_prdata[14:12] <= 3'h5 && o_prdata[11:8] <= 4'h9) else $error("seconds not BCD 0 to 59");
    hour_range_a: assert property (rd && i_paddr == rtcas_pkg::OFS_HM |->
        o_prdata[13:8] <= 6'h23 && o_prdata[11:8] <= 4'h9) else $error("hour count out of range");
    rst_bit_a: assert property (acc && i_pwrite && i_paddr == rtcas_pkg::OFS_CTRL && i_pwdata[1] ##2
        rd && i_paddr == rtcas_pkg::OFS_CTRL |-> o_prdata[1]) else $error("reset bit not 1 while running");

    sw_seen_c: cover property (rd && i_paddr == rtcas_pkg::OFS_SW_CTRL && o_prdata[15:12] != 4'h0);
    busy_seen_c: cover property (rd && i_paddr == rtcas_pkg::OFS_CTRL && o_prdata[6]);
    unmapped_c: cover property (acc && !map);
endmodule

bind rtcas_top rtcas_top_checker chk (.i_clk, .i_nrst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
    .o_prdata, .o_pready, .o_pslverr);

// [tb/tb_top.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------
// Register-level bench for the clock block
// ------------------------------------------------------------
module tb_top;
    logic i_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic i_psel = 1'b0;
    logic i_penable = 1'b0;
    logic i_pwrite = 1'b0;
    logic [7:0] i_paddr = 8'h00;
    logic [31:0] i_pwdata = 32'h0000_0000;
    logic [31:0] o_prdata;
    logic o_pready;
    logic o_pslverr;
    logic [31:0] rd_v;
    logic [31:0] v1;
    logic err_v;
    int fail_count = 0;
    int samples_checked = 0;
    int n;

    // Clock of 50 ns period.
    always #25 i_clk = ~i_clk;

    rtcas_top #(.P_TICK_CYCLES(4), .P_SW_CYCLES(5)) dut (.i_clk, .i_nrst, .i_psel, .i_penable, .i_pwrite,
        .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr);

    // Compares one value and reports a difference at once.
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer; psel stays up so a further call is a direct setup.
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int k;
        k = 0;
        i_psel <= 1'b1;
        i_paddr <= a;
        i_pwrite <= w;
        i_pwdata <= d;
        @(posedge i_clk);
        i_penable <= 1'b1;
        @(posedge i_clk);
        while (o_pready !== 1'b1 && k < 16) begin
            k++;
            @(posedge i_clk);
        end
        rd_v = o_prdata;
        err_v = o_pslverr;
        i_penable <= 1'b0;
    endtask

    // Releases the bus and lets cycles pass.
    task automatic idle(input int c);
        i_psel <= 1'b0;
        repeat (c) @(posedge i_clk);
    endtask

    // Write, and read with comparison.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(a, 1'b1, d);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        apb(a, 1'b0, 32'h0000_0000);
        check(rd_v, e);
    endtask

    // Polls the control register until the busy flag shows.
    task automatic wait_busy;
        int k;
        k = 0;
        rd_v = 32'h0000_0000;
        while (rd_v[rtcas_pkg::CTRL_BUSY] !== 1'b1 && k < 600) begin
            k++;
            apb(rtcas_pkg::OFS_CTRL, 1'b0, 32'h0000_0000);
        end
        check(rd_v & 32'h0000_0040, 32'h0000_0040);
    endtask

    // Reset values of every register and a refused unmapped read.
    task automatic t_reset;
        logic [31:0] ev [7];
        ev = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0000_1200, 32'h0};
        for (int i = 0; i < 7; i++) begin
            rc(8'(i * 4), ev[i]);
        end
        rc(8'h1C, 32'h0000_0000);
        check({31'h0, err_v}, 32'h0000_0001);
    endtask

    // Alarm fields keep only their bits; stopwatch digits ignore writes.
    task automatic t_alarm_regs;
        wr(rtcas_pkg::OFS_SEC_ALARM, 32'hFFFF_FFFF);
        rc(rtcas_pkg::OFS_SEC_ALARM, 32'h0000_7F00);
        wr(rtcas_pkg::OFS_HM_ALARM, 32'hFFFF_FFFF);
        rc(rtcas_pkg::OFS_HM_ALARM, 32'h0000_7F7F);
        wr(rtcas_pkg::OFS_SW_CTRL, 32'h0000_FFEE);
        rc(rtcas_pkg::OFS_SW_CTRL, 32'h0000_0000);
        idle(1);
    endtask

    // Stopwatch run, stop with hold, clear when idle and when running.
    task automatic t_stopwatch;
        wr(rtcas_pkg::OFS_SW_CTRL, 32'h0000_0001);
        idle(60);
        wr(rtcas_pkg::OFS_SW_CTRL, 32'h0000_0000);
        idle(12);
        apb(rtcas_pkg::OFS_SW_CTRL, 1'b0, 32'h0);
        v1 = rd_v;
        n = v1[15:12] * 10 + v1[11:8];
        check({31'h0, n >= 11 && n <= 14}, 32'h0000_0001);
        idle(30);
        rc(rtcas_pkg::OFS_SW_CTRL, v1);
        wr(rtcas_pkg::OFS_SW_CTRL, 32'h0000_0010);
        idle(1);
        rc(rtcas_pkg::OFS_SW_CTRL, 32'h0000_0000);
        wr(rtcas_pkg::OFS_SW_CTRL, 32'h0000_0001);
        idle(40);
        rd_v = 32'h0000_0000;
        v1 = 32'h0000_0001;
        while (rd_v !== v1) begin
            apb(rtcas_pkg::OFS_SW_CTRL, 1'b0, 32'h0);
            v1 = rd_v;
            apb(rtcas_pkg::OFS_SW_CTRL, 1'b0, 32'h0);
        end
        check({31'h0, rd_v[0] && rd_v[15:8] != 8'h00}, 32'h0000_0001);
        wr(rtcas_pkg::OFS_SW_CTRL, 32'h0000_0011);
        idle(25);
        wr(rtcas_pkg::OFS_SW_CTRL, 32'h0000_0000);
        idle(12);
        apb(rtcas_pkg::OFS_SW_CTRL, 1'b0, 32'h0);
        n = rd_v[15:12] * 10 + rd_v[11:8];
        check({31'h0, n >= 3 && n <= 7}, 32'h0000_0001);
        idle(1);
    endtask

    // Second counting, stop and resume, taps, busy and prescaler reset.
    task automatic t_seconds;
        wr(rtcas_pkg::OFS_SEC, 32'h0000_5800);
        rc(rtcas_pkg::OFS_SEC, 32'h0000_5800);
        wr(rtcas_pkg::OFS_CTRL, 32'h0000_0003);
        wait_busy();
        apb(rtcas_pkg::OFS_SEC, 1'b0, 32'h0);
        check(rd_v & 32'h0000_FF00, 32'h0000_5900);
        idle(8);
        rc(rtcas_pkg::OFS_CTRL, 32'h0000_0001);
        idle(1100);
        wr(rtcas_pkg::OFS_CTRL, 32'h0000_0000);
        apb(rtcas_pkg::OFS_SEC, 1'b0, 32'h0);
        v1 = rd_v;
        check(v1 & 32'h0000_FF00, 32'h0000_0000);
        check({31'h0, v1[7:0] != 8'h00}, 32'h0000_0001);
        idle(200);
        rc(rtcas_pkg::OFS_SEC, v1);
        wr(rtcas_pkg::OFS_CTRL, 32'h0000_0001);
        wait_busy();
        wr(rtcas_pkg::OFS_CTRL, 32'h0000_0002);
        rc(rtcas_pkg::OFS_CTRL, 32'h0000_0002);
        rc(rtcas_pkg::OFS_SEC, 32'h0000_0100);
        idle(5);
        rc(rtcas_pkg::OFS_CTRL, 32'h0000_0000);
    endtask

    // Hour mode, half-day handling and hour roll-over.
    task automatic t_hours;
        wr(rtcas_pkg::OFS_HM, 32'h0000_5159);
        rc(rtcas_pkg::OFS_HM, 32'h0000_5159);
        wr(rtcas_pkg::OFS_CTRL, 32'h0000_0010);
        rc(rtcas_pkg::OFS_HM, 32'h0000_1159);
        wr(rtcas_pkg::OFS_SEC, 32'h0000_5900);
        wr(rtcas_pkg::OFS_CTRL, 32'h0000_0013);
        wait_busy();
        wr(rtcas_pkg::OFS_CTRL, 32'h0000_0010);
        rc(rtcas_pkg::OFS_HM, 32'h0000_1200);
        wr(rtcas_pkg::OFS_CTRL, 32'h0000_0000);
        rc(rtcas_pkg::OFS_HM, 32'h0000_1200);
        wr(rtcas_pkg::OFS_CTRL, 32'h0000_0010);
        wr(rtcas_pkg::OFS_HM, 32'h0000_6359);
        rc(rtcas_pkg::OFS_HM, 32'h0000_2359);
        wr(rtcas_pkg::OFS_SEC, 32'h0000_5900);
        wr(rtcas_pkg::OFS_CTRL, 32'h0000_0013);
        wait_busy();
        wr(rtcas_pkg::OFS_CTRL, 32'h0000_0010);
        rc(rtcas_pkg::OFS_HM, 32'h0000_0000);
        wr(rtcas_pkg::OFS_CTRL, 32'h0000_0000);
        wr(rtcas_pkg::OFS_HM, 32'h0000_1159);
        wr(rtcas_pkg::OFS_SEC, 32'h0000_5900);
        wr(rtcas_pkg::OFS_CTRL, 32'h0000_0003);
        wait_busy();
        wr(rtcas_pkg::OFS_CTRL, 32'h0000_0000);
        rc(rtcas_pkg::OFS_HM, 32'h0000_5200);
    endtask

    // Alarm match in 24-hour mode with the half-day setting disregarded.
    task automatic t_alarm;
        wr(rtcas_pkg::OFS_SEC_ALARM, 32'h0000_0100);
        wr(rtcas_pkg::OFS_HM_ALARM, 32'h0000_1200);
        rc(rtcas_pkg::OFS_STATUS, 32'h0000_0000);
        wr(rtcas_pkg::OFS_CTRL, 32'h0000_0013);
        wait_busy();
        idle(8);
        rc(rtcas_pkg::OFS_STATUS, 32'h0000_0001);
        wr(rtcas_pkg::OFS_STATUS, 32'h0000_0001);
        rc(rtcas_pkg::OFS_STATUS, 32'h0000_0000);
        wr(rtcas_pkg::OFS_CTRL, 32'h0000_0010);
        idle(2);
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Watchdog against a hung wait.
    initial begin
        repeat (60000) @(posedge i_clk);
        fail_count++;
        end_of_test();
    end

    // Main sequence.
    initial begin
        repeat (12) @(posedge i_clk);
        i_nrst <= 1'b1;
        @(posedge i_clk);
        t_reset();
        t_alarm_regs();
        t_stopwatch();
        t_seconds();
        t_hours();
        t_alarm();
        end_of_test();
    end
endmodule
